// file: inc/mtou_pkg.sv
// Package of constants and types for the microcode trace output unit
package mtou_pkg;

	// Register data and address widths
	localparam int unsigned DATA_W = 16;
	localparam int unsigned ADDR_W = 9;

	// Register offsets (register index, not byte address)
	localparam logic [8:0] TRACE_START_OFS  = 9'h1AA;
	localparam logic [8:0] TRACE_STOP_OFS   = 9'h1AB;
	localparam logic [8:0] TRACE_CONFIG_OFS = 9'h1AC;
	localparam logic [8:0] TRACE_STATUS_OFS = 9'h1AD;

	// Field layout
	localparam int unsigned PC_W      = 10;
	localparam int unsigned CORE_W    = 2;
	localparam int unsigned POST_W    = 8;
	localparam int unsigned CODE_W    = 4;
	localparam int unsigned EN_POS    = 15;
	localparam int unsigned CORE_POS  = 8;
	localparam int unsigned POST_POS  = 0;

	// Reset values
	localparam logic [PC_W-1:0]   START_RST = 10'h000;
	localparam logic [PC_W-1:0]   STOP_RST  = 10'h000;
	localparam logic [CORE_W-1:0] CORE_RST  = 2'h0;
	localparam logic [POST_W-1:0] POST_RST  = 8'h00;

	// Post-trigger length that never expires
	localparam logic [POST_W-1:0] POST_FOREVER = 8'hFF;

	// Timing: clk_i is the serial bit clock, four bits per sequencer cycle
	localparam int unsigned SEQ_DIV    = CODE_W;
	localparam logic [1:0]  PHASE_LAST = 2'h3;
	// Calibration: eight periods at half the sequencer rate = 16 sequencer cycles
	localparam int unsigned CAL_PERIODS = 8;
	localparam logic [4:0]  CAL_LAST    = 5'(2 * CAL_PERIODS - 1);
	// Low gap after calibration, in sequencer cycles
	localparam int unsigned GAP_SEQ     = 1;

	typedef struct packed {
		logic              enable;
		logic [CORE_W-1:0] core_choice_field;
		logic [POST_W-1:0] post_len;
	} mtou_cfg_s;

	typedef enum logic [5:0] {
		ST_OFF   = 6'b000001,
		ST_CAL   = 6'b000010,
		ST_GAP   = 6'b000100,
		ST_IDLE  = 6'b001000,
		ST_TRACE = 6'b010000,
		ST_POST  = 6'b100000
	} mtou_state_e;

endpackage

// file: tb/mtou_capture_model.sv
// Behavioural trace capture board listening on the debug pin
`timescale 1ns/100ps
module mtou_capture_model (
	input  wire logic  clk_i,
	input  wire logic  arm_i,
	input  wire logic  pin_i,
	output logic       locked_o,
	output logic [15:0] n_o,
	output logic [9:0] pc_o
);
	logic [3:0] sh;
	logic [1:0] bit_q;
	logic       prev;
	logic       run;
	int         rises;
	int         lows;
	// Zero nibbles are not counted, so idle low time never inflates the code count
	always @(posedge clk_i) begin
		prev <= pin_i;
		if (!arm_i) begin
			{locked_o, run, bit_q, n_o} <= '0;
			rises <= 0;
			lows <= 0;
			pc_o <= 10'h048;
		end else if (!locked_o) begin
			if (pin_i && !prev) rises <= rises + 1;
			lows <= pin_i ? 0 : lows + 1;
			if (rises == 8 && lows >= 7) locked_o <= 1'b1;
		end else if (run || pin_i) begin
			run <= 1'b1;
			sh <= {sh[2:0], pin_i};
			bit_q <= bit_q + 2'h1;
			if (bit_q == 2'h3 && {sh[2:0], pin_i} != 4'h0) begin
				n_o <= n_o + 16'h1;
				pc_o <= pc_o + 10'({sh[2:0], pin_i});
			end
		end
	end
endmodule

// file: tb/mtou_trace_checker.sv
// Concurrent checks on the trace unit ports
`timescale 1ns/100ps
module mtou_trace_checker
	import mtou_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              srst_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic              reg_we_i,
	input wire logic              reg_re_i,
	input wire logic [DATA_W-1:0] reg_rdata_o,
	input wire logic              debug_trace_pin_o
);
	logic [DATA_W-1:0] cfg_q;
	logic [PC_W-1:0]   start_q;
	logic              en;
	logic              pin;
	assign en = cfg_q[EN_POS];
	assign pin = debug_trace_pin_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// Shadow copy; reserved config bits are expected to read back as zero
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg_q <= '0;
			start_q <= '0;
		end else if (reg_we_i && reg_addr_i == TRACE_CONFIG_OFS) begin
			cfg_q <= reg_wdata_i & 16'h83FF;
		end else if (reg_we_i && reg_addr_i == TRACE_START_OFS) begin
			start_q <= reg_wdata_i[PC_W-1:0];
		end
	end
	AST_CAL_SHAPE: assert property (
		$rose(en) ##[1:8] $rose(pin) |-> pin [*4] ##1 !pin [*4]) else $error("burst shape");
	AST_CAL_END: assert property (
		$rose(en) ##[1:8] $rose(pin) |-> ##56 $rose(pin) ##4 !pin [*8]) else $error("burst end");
	AST_OFF_QUIET: assert property (!en [*4] |-> !pin) else $error("pin not low");
	AST_DIS_STOP: assert property ($fell(en) |-> ##2 !pin [*8]) else $error("no stop");
	AST_DIS_STATE: assert property (
		!en [*4] ##0 (reg_re_i && reg_addr_i == TRACE_STATUS_OFS) |=> reg_rdata_o[5:0] == 6'h01)
		else $error("not off");
	AST_START_RD: assert property (
		reg_re_i && reg_addr_i == TRACE_START_OFS |=> reg_rdata_o == DATA_W'(start_q))
		else $error("start readback");
	AST_CFG_RD: assert property (
		reg_re_i && reg_addr_i == TRACE_CONFIG_OFS |=> reg_rdata_o == cfg_q) else $error("cfg readback");
	AST_RD_IDLE: assert property (!$past(reg_re_i) |-> reg_rdata_o == '0) else $error("stray data");
endmodule

bind mtou_trace mtou_trace_checker u_chk (
	.clk_i(clk_i),
	.srst_i(srst_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_we_i(reg_we_i),
	.reg_re_i(reg_re_i),
	.reg_rdata_o(reg_rdata_o),
	.debug_trace_pin_o(debug_trace_pin_o)
);

// file: tb/tb.sv
// Self-checking testbench for the microcode trace output unit
`timescale 1ns/100ps
module tb;
	import mtou_pkg::*;
	logic                 clk_i, srst_i, we, re, arm, lk, pin;
	logic [ADDR_W-1:0]    addr;
	logic [DATA_W-1:0]    wdata, rdata, v, n, nv;
	logic [9:0]           pcm;
	logic [3:0][PC_W-1:0] pc;
	int                   error_cnt, checks_done, cyc;

	mtou_trace uut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .microcode_program_counter_i(pc),
		.path_code_i({4'hC, 4'hB, 4'hA, 4'h9}), .debug_trace_pin_o(pin));
	mtou_capture_model cap (.clk_i(clk_i), .arm_i(arm), .pin_i(pin), .locked_o(lk), .n_o(n),
		.pc_o(pcm));

	always #2.5 clk_i = ~clk_i;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk_i);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a);
		@(posedge clk_i);
		addr <= a;
		re <= 1'b1;
		@(posedge clk_i);
		re <= 1'b0;
		#1 v = rdata;
	endtask
	// Any four consecutive bit clocks hold exactly one sequencer tick
	task automatic hold(input logic [9:0] val, input int k);
		@(posedge clk_i);
		pc[2] <= val;
		repeat (k - 1) @(posedge clk_i);
	endtask
	task automatic stop_test;
		if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		{clk_i, we, re, arm} = '0;
		srst_i = 1'b1;
		addr = '0;
		wdata = '0;
		pc = {4{10'h050}};
		{error_cnt, checks_done, cyc} = '0;
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(TRACE_CONFIG_OFS);
		chk(v, 16'h0000);
		rd(9'h1FF);
		chk(v, 16'h0000);
		wr(TRACE_START_OFS, 16'hFC48);
		wr(TRACE_STOP_OFS, 16'h0071);
		rd(TRACE_START_OFS);
		chk(v, 16'h0048);
		arm <= 1'b1;
		wr(TRACE_CONFIG_OFS, 16'h8203);
		rd(TRACE_CONFIG_OFS);
		chk(v, 16'h8203);
		for (int i = 0; i < 200 && !lk; i++) @(posedge clk_i);
		chk({15'h0, lk}, 16'h0001);
		pc[0] <= 10'h048;
		repeat (8) @(posedge clk_i);
		pc[0] <= 10'h050;
		repeat (8) @(posedge clk_i);
		chk(n, 16'h0000);
		hold(10'h048, 4);
		hold(10'h050, 8);
		hold(10'h071, 4);
		hold(10'h050, 4);
		repeat (60) @(posedge clk_i);
		rd(TRACE_STATUS_OFS);
		chk(v & 16'h003F, 16'h0008);
		chk(n, 16'h0007);
		chk({6'h0, pcm}, 16'h0095);
		wr(TRACE_CONFIG_OFS, 16'h82FF);
		hold(10'h048, 4);
		hold(10'h050, 4);
		hold(10'h071, 4);
		hold(10'h050, 4);
		repeat (120) @(posedge clk_i);
		rd(TRACE_STATUS_OFS);
		chk(v & 16'h003F, 16'h0020);
		chk({15'h0, n > 16'h0023}, 16'h0001);
		wr(TRACE_CONFIG_OFS, 16'h0000);
		repeat (8) @(posedge clk_i);
		rd(TRACE_STATUS_OFS);
		chk(v & 16'h003F, 16'h0001);
		nv = n;
		repeat (40) @(posedge clk_i);
		chk(n, nv);
		stop_test();
	end
endmodule

// file: verilog/mtou_trace.sv
// Microcode trace output unit: calibration, start/stop trigger and serial path-code stream
//
// Summary of operation
// [RULE1] Enabling trace sends eight clock periods at half the sequencer rate on pin.
// [RULE2] After the burst the pin stays low at least one sequencer cycle.
// [RULE3] Tracer shares no clock; it locks its sampling onto the calibration burst.
// [RULE4] With trace enabled and engine idle, tracing starts when selected PC equals start.
// [RULE5] Start address is written by software through the register port.
// [RULE6] While tracing, one 4-bit path code leaves every sequencer cycle.
// [RULE7] Codes carry PC changes; tracer accumulates them from the known start address.
// [RULE8] Reaching the stop address while tracing moves the engine to post-trigger.
// [RULE9] Writing enable to 0 stops tracing at any time.
// [RULE10] Post-trigger emits codes for the programmed cycle count, then returns to idle.
// [RULE11] A post-trigger length of all ones never expires; only disable stops it.
// [RULE12] Config register holds enable, core choice and post-trigger length.
// [RULE13] Pin stays low while disabled or idle after calibration.
`timescale 1ns/100ps
module mtou_trace
	import mtou_pkg::*;
#(
	parameter int unsigned NCORES = 4
) (
	input  wire logic                              clk_i,
	input  wire logic                              srst_i,
	input  wire logic [ADDR_W-1:0]                 reg_addr_i,
	input  wire logic [DATA_W-1:0]                 reg_wdata_i,
	input  wire logic                              reg_we_i,
	input  wire logic                              reg_re_i,
	output logic      [DATA_W-1:0]                 reg_rdata_o,
	input  wire logic [NCORES-1:0][PC_W-1:0]       microcode_program_counter_i,
	input  wire logic [NCORES-1:0][CODE_W-1:0]     path_code_i,
	output logic                                   debug_trace_pin_o
);

	mtou_cfg_s         cfg_q;
	logic [PC_W-1:0]   start_q;
	logic [PC_W-1:0]   stop_q;
	mtou_state_e       state_q;
	logic [1:0]        phase_q;
	logic [4:0]        cal_cnt_q;
	logic [POST_W-1:0] post_cnt_q;
	logic [CODE_W-1:0] shift_q;
	logic              en_prev_q;
	logic              tick;
	logic              cfg_wr;
	logic              wr_en;
	logic [CODE_W-1:0] sel_code;

	logic [NCORES-1:0] start_hit;
	logic [NCORES-1:0] stop_hit;
	logic              start_now;
	logic              stop_now;
	logic              post_live;
	logic              code_due;

	logic              start_wr;
	logic              stop_wr;
	logic [DATA_W-1:0] rdata_d;
	logic              pin_d;

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [8:0] ofs);
		addr_hit = (a == ofs);
	endfunction

	// A tail length of all ones is the endless tail
	function automatic logic tail_running(input logic [POST_W-1:0] cnt,
	                                      input logic [POST_W-1:0] len);
		tail_running = (len == POST_FOREVER) || (cnt != len);
	endfunction

	// Sequencer cycle boundary: last bit of the current code is on pin_d, one clock before it reaches the pin
	assign tick     = (phase_q == PHASE_LAST);
	assign cfg_wr    = reg_we_i && addr_hit(reg_addr_i, TRACE_CONFIG_OFS);
	assign start_wr  = reg_we_i && addr_hit(reg_addr_i, TRACE_START_OFS);
	assign stop_wr   = reg_we_i && addr_hit(reg_addr_i, TRACE_STOP_OFS);
	assign wr_en     = reg_wdata_i[EN_POS];
	assign sel_code  = path_code_i[cfg_q.core_choice_field];
	assign start_now = start_hit[cfg_q.core_choice_field];
	assign stop_now  = stop_hit[cfg_q.core_choice_field];
	assign post_live = tail_running(post_cnt_q, cfg_q.post_len);

	// Two comparators per core, start and stop; the core choice then only steers a single bit of each
	for (genvar c = 0; c < NCORES; c++) begin : g_core
		assign start_hit[c] = (microcode_program_counter_i[c] == start_q);
		assign stop_hit[c]  = (microcode_program_counter_i[c] == stop_q);
	end

	// Whether the code of this sequencer cycle goes out on the pin
	always_comb begin
		code_due = 1'b0;
		case (state_q)
			ST_IDLE: begin
				code_due = start_now; // [RULE4]
			end
			ST_TRACE: begin
				code_due = 1'b1; // [RULE6]
			end
			ST_POST: begin
				code_due = post_live; // [RULE10] [RULE11]
			end
			default: begin
				code_due = 1'b0;
			end
		endcase
	end

	// Start and stop addresses; upper bits of the written word are dropped
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			start_q <= START_RST;
		end else if (start_wr) begin
			start_q <= reg_wdata_i[PC_W-1:0]; // [RULE5]
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			stop_q <= STOP_RST;
		end else if (stop_wr) begin
			stop_q <= reg_wdata_i[PC_W-1:0];
		end
	end

	// Configuration; one write may change enable, core choice and tail length at once
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cfg_q <= '{enable: 1'b0, core_choice_field: CORE_RST, post_len: POST_RST};
		end else if (cfg_wr) begin
			cfg_q.enable            <= wr_en; // [RULE12]
			cfg_q.core_choice_field <= reg_wdata_i[CORE_POS +: CORE_W]; // [RULE12]
			cfg_q.post_len          <= reg_wdata_i[POST_POS +: POST_W]; // [RULE12]
		end
	end

	// Read mux; unmapped indices read as zero
	always_comb begin
		rdata_d = '0;
		case (reg_addr_i)
			TRACE_START_OFS: begin
				rdata_d[PC_W-1:0] = start_q;
			end
			TRACE_STOP_OFS: begin
				rdata_d[PC_W-1:0] = stop_q;
			end
			TRACE_CONFIG_OFS: begin
				rdata_d[EN_POS]             = cfg_q.enable;
				rdata_d[CORE_POS +: CORE_W] = cfg_q.core_choice_field;
				rdata_d[POST_POS +: POST_W] = cfg_q.post_len;
			end
			TRACE_STATUS_OFS: begin
				rdata_d[5:0]                    = state_q;
				rdata_d[POST_POS + 8 +: POST_W] = post_cnt_q;
			end
			default: begin
				rdata_d = '0;
			end
		endcase
	end

	// Read data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk_i) begin
		if (srst_i || !reg_re_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			reg_rdata_o <= rdata_d;
		end
	end

	// Free-running bit phase inside a sequencer cycle
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// Remembers the enable level so a 0-to-1 change restarts calibration
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			en_prev_q <= 1'b0;
		end else if (state_q == ST_OFF && tick) begin
			en_prev_q <= cfg_q.enable;
		end else if (!cfg_q.enable) begin
			en_prev_q <= 1'b0;
		end
	end

	// Trace engine; moves only on sequencer boundaries, except that disable acts at once
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= ST_OFF;
		end else if (!cfg_q.enable) begin
			state_q <= ST_OFF; // [RULE9]
		end else if (tick) begin
			case (state_q)
				ST_OFF: begin
					if (!en_prev_q) begin
						state_q <= ST_CAL; // [RULE1]
					end
				end
				ST_CAL: begin
					if (cal_cnt_q == CAL_LAST) begin
						state_q <= ST_GAP; // [RULE2]
					end
				end
				ST_GAP: begin
					state_q <= ST_IDLE; // [RULE2]
				end
				ST_IDLE: begin
					if (start_now) begin
						state_q <= ST_TRACE; // [RULE4]
					end
				end
				ST_TRACE: begin
					if (stop_now) begin
						state_q <= ST_POST; // [RULE8]
					end
				end
				ST_POST: begin
					// An all-ones length keeps the tail alive until disable
					if (!post_live) begin
						state_q <= ST_IDLE; // [RULE10] [RULE11]
					end
				end
				default: begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

	// Calibration period counter, one step per sequencer cycle of the burst
	always_ff @(posedge clk_i) begin
		if (srst_i || !cfg_q.enable) begin
			cal_cnt_q <= 5'h00;
		end else if (tick && state_q == ST_OFF) begin
			cal_cnt_q <= 5'h00;
		end else if (tick && state_q == ST_CAL && cal_cnt_q != CAL_LAST) begin
			cal_cnt_q <= cal_cnt_q + 5'h01; // [RULE1]
		end
	end

	// Tail counter; cleared on the stop hit, frozen for the endless tail
	always_ff @(posedge clk_i) begin
		if (srst_i || !cfg_q.enable) begin
			post_cnt_q <= POST_RST;
		end else if (tick && state_q == ST_TRACE && stop_now) begin
			post_cnt_q <= POST_RST; // [RULE8]
		end else if (tick && state_q == ST_POST && cfg_q.post_len != POST_FOREVER &&
		             post_live) begin
			post_cnt_q <= post_cnt_q + 8'h01; // [RULE10]
		end
	end

	// Code serialiser: one 4-bit code per sequencer cycle, MSB first
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			shift_q <= 4'h0;
		end else if (tick) begin
			if (cfg_q.enable && code_due) begin
				shift_q <= sel_code; // [RULE6]
			end else begin
				shift_q <= 4'h0;
			end
		end else begin
			shift_q <= {shift_q[CODE_W-2:0], 1'b0};
		end
	end

	// Pin level for the next bit time; only the burst and the code stream raise it
	always_comb begin
		pin_d = 1'b0;
		if (cfg_q.enable) begin
			case (state_q)
				ST_CAL: begin
					// High one sequencer cycle, low the next: half the sequencer rate
					pin_d = ~cal_cnt_q[0]; // [RULE1]
				end
				ST_GAP: begin
					pin_d = 1'b0; // [RULE2]
				end
				ST_TRACE, ST_POST: begin
					pin_d = shift_q[CODE_W-1]; // [RULE6]
				end
				default: begin
					pin_d = 1'b0; // [RULE13]
				end
			endcase
		end
	end

	// Registered so decode glitches never reach the tracer
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			debug_trace_pin_o <= 1'b0;
		end else begin
			debug_trace_pin_o <= pin_d; // [RULE13]
		end
	end

endmodule
